/* bench/sdpr_host.sv */
// Host controller model for one RAM port: makes the port clock and pins.
// Assumes clk_sys at 100 MHz; one port cycle spans seven system cycles.
`timescale 1ns/1ps
module sdpr_host (
    input  wire logic        clk_sys, // System clock
    output logic             pclk,    // Port clock, idle low
    output logic [9:0]       ctl,     // {lat,oen,cs0n,cs1,rw,ubn,lbn,adsn,advn,clrn}
    output logic [14:0]      addr,    // Address
    output logic [17:0]      din      // Data pin level
);
    // Idle: deselected, read, no counter action
    initial begin
        pclk = 1'b0;
        ctl = 10'h1bf;
        addr = 15'h0000;
        din = 18'h00000;
    end
    // Pins settle a cycle before the rise and hold six after it
    task automatic cyc(input logic [9:0] c, input logic [14:0] a, input logic [17:0] d);
        @(negedge clk_sys);
        ctl = c;
        addr = a;
        din = c[5] ? ~din : d; // Released lines show no stale value
        @(negedge clk_sys);
        pclk = 1'b1;
        repeat (3) @(negedge clk_sys);
        pclk = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
endmodule

/* bench/sdpr_properties.sv */
// Port pin checks for the two-port RAM, watching top-level ports only.
// Assumes one system clock and the bind after the module.
`timescale 1ns/1ps
module sdpr_properties
    import sdpr_pkg::*;
(
    input wire logic                                             clk_sys,               // Clock
    input wire logic                                             nrst,                  // Reset, low
    input wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0]              port_clk,              // Port clocks
    input wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0]              output_enable_n,       // Lane enable
    input wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0]              output_latency_select, // High pipe
    input wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0][sdpr_pkg::SDPR_DATA_W-1:0] data_pins_out, // Read data
    input wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0][sdpr_pkg::SDPR_DATA_W-1:0] data_pins_oe,  // Drive
    input wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0]              port_active            // Not standby
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Six cycles without a port clock or latency change leave nothing in flight
    sequence quiet(p);
        ($stable(port_clk[p]) && $stable(output_latency_select[p]))[*6];
    endsequence
    reset_clear_a: assert property ($rose(nrst) |-> port_active == 2'h0 && data_pins_oe == '0 && data_pins_out == '0)
        else $error("outputs not clear after reset");
    desel_float0_a: assert property (!port_active[0] |-> data_pins_oe[0] == '0)
        else $error("port 0 drives while in standby");
    desel_float1_a: assert property (!port_active[1] |-> data_pins_oe[1] == '0)
        else $error("port 1 drives while in standby");
    lane_whole0_a: assert property (data_pins_oe[0] inside {18'h00000, 18'h001ff, 18'h3fe00, 18'h3ffff})
        else $error("port 0 lane drive split");
    lane_whole1_a: assert property (data_pins_oe[1] inside {18'h00000, 18'h001ff, 18'h3fe00, 18'h3ffff})
        else $error("port 1 lane drive split");
    oe_disable0_a: assert property (output_enable_n[0] [*4] |-> data_pins_oe[0] == '0)
        else $error("port 0 drives with output enable high");
    oe_disable1_a: assert property (output_enable_n[1] [*4] |-> data_pins_oe[1] == '0)
        else $error("port 1 drives with output enable high");
    quiet_hold0_a: assert property (quiet(0) |=> $stable(data_pins_out[0]) && $stable(port_active[0]))
        else $error("port 0 changed without a port edge");
    quiet_hold1_a: assert property (quiet(1) |=> $stable(data_pins_out[1]) && $stable(port_active[1]))
        else $error("port 1 changed without a port edge");
endmodule

bind sdpr_top sdpr_properties PROPS (.clk_sys(clk_sys), .nrst(nrst), .port_clk(port_clk),
    .output_enable_n(output_enable_n), .output_latency_select(output_latency_select),
    .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe), .port_active(port_active));

/* bench/sdpr_top_bench.sv */
// Self-checking bench for the two-port RAM port logic.
// Assumes the host models drive pins; ports are used one at a time.
`timescale 1ns/1ps
module sdpr_top_bench;
    import sdpr_pkg::*;
    logic clk_sys;
    logic nrst;
    wire [1:0] pclk;
    wire [1:0][9:0] ctl;
    wire [1:0][14:0] addr;
    wire [1:0][17:0] din;
    logic [1:0][17:0] dout, doe;
    logic [1:0] act;
    logic [17:0] mem [int];
    logic [17:0] flow [2];
    int cnt [2];
    int failures = 0;
    int n_tests = 0;
    logic [31:0] rs = 32'h7183ce4d;
    int i;

    sdpr_host H0 (.clk_sys(clk_sys), .pclk(pclk[0]), .ctl(ctl[0]), .addr(addr[0]), .din(din[0]));
    sdpr_host H1 (.clk_sys(clk_sys), .pclk(pclk[1]), .ctl(ctl[1]), .addr(addr[1]), .din(din[1]));
    sdpr_top DUT (.clk_sys(clk_sys), .nrst(nrst), .port_clk(pclk),
        .primary_select_n({ctl[1][7], ctl[0][7]}), .secondary_select({ctl[1][6], ctl[0][6]}),
        .read_write({ctl[1][5], ctl[0][5]}), .output_enable_n({ctl[1][8], ctl[0][8]}),
        .upper_byte_select_n({ctl[1][4], ctl[0][4]}), .lower_byte_select_n({ctl[1][3], ctl[0][3]}),
        .address_load_strobe_n({ctl[1][2], ctl[0][2]}), .counter_advance_n({ctl[1][1], ctl[0][1]}),
        .counter_clear_n({ctl[1][0], ctl[0][0]}), .output_latency_select({ctl[1][9], ctl[0][9]}),
        .address(addr), .data_pins_in(din), .data_pins_out(dout), .data_pins_oe(doe), .port_active(act));

    // 100 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction

    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One port cycle plus the reference model of counter, array and flow-through output
    task automatic op(input int p, input logic [9:0] c, input logic [14:0] a, input logic [17:0] d);
        logic sel;
        logic [17:0] m, eo, w;
        if (p == 0) H0.cyc(c, a, d);
        else H1.cyc(c, a, d);
        if (!c[0]) cnt[p] = 0;
        else if (!c[2]) cnt[p] = a;
        else if (!c[1]) cnt[p] = (cnt[p] + 1) & 32'h7fff;
        sel = !c[7] && c[6];
        m = {{9{!c[4]}}, {9{!c[3]}}};
        w = mem.exists(cnt[p]) ? mem[cnt[p]] : 18'hx;
        if (sel && !c[5]) mem[cnt[p]] = (w & ~m) | (d & m);
        if (sel && c[5]) flow[p] = w;
        eo = (sel && c[5] && !c[8]) ? m : 18'h00000;
        if (!c[9]) begin
            check("active", {17'h0, act[p]}, {17'h0, sel});
            check("lanes", doe[p], eo);
            if ((^(flow[p] & eo)) !== 1'bx) check("data", dout[p] & eo, flow[p] & eo);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Main sequence: reset, seed the array, random traffic, then pipelined corners
    initial begin
        nrst = 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        op(0, 10'h1be, 15'h0000, 18'h00000);
        op(1, 10'h1be, 15'h0000, 18'h00000);
        for (i = 0; i < 16; i++) begin
            rs = lfsr(rs);
            op(i % 2, 10'h143, i[14:0], rs[17:0]);
        end
        // Ports take turns, so no same-word clash ever arises
        for (i = 0; i < 60; i++) begin
            rs = lfsr(rs);
            op(rs[31], {1'b0, rs[8], rs[7] & rs[10], rs[6] | rs[11], rs[5:1], rs[0] | rs[12]},
                {rs[13], 10'h000, rs[17:14]}, 18'(lfsr(rs) >> 3));
        end
        // Upper byte dropped on the second pipelined read: lanes follow it at once
        op(0, 10'h263, 15'h0002, 18'h00000);
        op(0, 10'h273, 15'h0005, 18'h00000);
        check("pipe data", dout[0], mem[2]);
        check("pipe lanes", doe[0], 18'h001ff);
        op(0, 10'h2e3, 15'h0007, 18'h00000);
        check("pipe active", {17'h0, act[0]}, 18'h00001);
        check("pipe data", dout[0], mem[5]);
        op(0, 10'h2e3, 15'h0007, 18'h00000);
        check("pipe active", {17'h0, act[0]}, 18'h00000);
        check("pipe lanes", doe[0], 18'h00000);
        op(0, 10'h063, 15'h0005, 18'h00000);
        give_verdict();
    end

    // Watchdog well beyond the expected run of about 600 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        give_verdict();
    end
endmodule

/* common/sdpr_pkg.sv */
// Shared constants for the two-port synchronous RAM port logic.
// Assumes one system clock; port clocks arrive as ordinary pins.
package sdpr_pkg;

    // ------------------------------------------------------------
    // Array shape
    // ------------------------------------------------------------
    localparam int SDPR_NUM_PORTS  = 2;
    localparam int SDPR_ADDR_W     = 15;
    localparam int SDPR_DATA_W     = 18;
    localparam int SDPR_BYTE_W     = 9;
    localparam int SDPR_SYNC_DEPTH = 2;

    // ------------------------------------------------------------
    // Layout of the sampled pin bundle of one port
    // ------------------------------------------------------------
    localparam int SDPR_DIN_LSB    = 0;
    localparam int SDPR_ADDR_LSB   = SDPR_DIN_LSB + SDPR_DATA_W;
    localparam int SDPR_LAT_BIT    = SDPR_ADDR_LSB + SDPR_ADDR_W;
    localparam int SDPR_CLR_BIT    = SDPR_LAT_BIT + 1;
    localparam int SDPR_ADV_BIT    = SDPR_LAT_BIT + 2;
    localparam int SDPR_ADS_BIT    = SDPR_LAT_BIT + 3;
    localparam int SDPR_LBN_BIT    = SDPR_LAT_BIT + 4;
    localparam int SDPR_UBN_BIT    = SDPR_LAT_BIT + 5;
    localparam int SDPR_OEN_BIT    = SDPR_LAT_BIT + 6;
    localparam int SDPR_RW_BIT     = SDPR_LAT_BIT + 7;
    localparam int SDPR_CS1_BIT    = SDPR_LAT_BIT + 8;
    localparam int SDPR_CS0N_BIT   = SDPR_LAT_BIT + 9;
    localparam int SDPR_PCLK_BIT   = SDPR_LAT_BIT + 10;
    localparam int SDPR_BUNDLE_W   = SDPR_PCLK_BIT + 1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SDPR_SYS_PERIOD_NS  = 10;
    localparam int SDPR_PORT_MIN_NS    = 10;
    // Each port edge needs sync, detect and settle: four system cycles
    localparam int SDPR_PORT_MIN_CYC   = 4;
    localparam int SDPR_PORT_CYC_SCALE = (SDPR_PORT_MIN_NS + SDPR_SYS_PERIOD_NS - 1) / SDPR_SYS_PERIOD_NS;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [SDPR_ADDR_W-1:0] SDPR_ADDR_ZERO = 15'h0000;
    localparam logic [SDPR_DATA_W-1:0] SDPR_DATA_ZERO = 18'h00000;
    localparam logic [SDPR_ADDR_W-1:0] SDPR_ADDR_ONE  = 15'h0001;

endpackage

/* rtl/sdpr_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes bits of the bundle are only used as a coherent sample
// when the source holds them steady across several system cycles.
`timescale 1ns/1ps
module sdpr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys, // System clock
    input  wire logic             nrst,    // Synchronous reset, active low
    input  wire logic [WIDTH-1:0] d,       // Asynchronous input
    output logic      [WIDTH-1:0] q        // Synchronised output
);
    logic [WIDTH-1:0] meta_reg;

    // Refuse a bundle of no bits at elaboration
    if (WIDTH < 1) begin : g_bad_width
        $error("sdpr_sync: WIDTH must be positive");
    end

    // ------------------------------------------------------------
    // First flop feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

/* rtl/sdpr_top.sv */
// Two-port synchronous RAM with per-port burst counter and
// selectable flow-through or pipelined read output.
// Assumes port clocks run at most a quarter of clk_sys and every
// port pin is held steady at least three system cycles after a port edge.
//
// Summary of operation
// - Two ports access any word concurrently
// - Words of 18 bits, two 9-bit bytes
// - Inputs except output enable and latency select sampled at edge
// - Each port follows its own clock
// - Latency select: low flow-through, high pipelined
// - Deselect floats pins and idles the port
// - Selects staged once, or twice when pipelined
// - Byte selects always staged once
// - Write only selected bytes, ignore output enable
// - Read drives only selected byte lanes
// - Output enable high floats both lanes
// - Write completes within one port cycle
// - Pipelined read data one cycle later
// - Counter clear wins, address goes zero
// - Address strobe loads external address
// - Advance increments, otherwise address held
`timescale 1ns/1ps
module sdpr_top
    import sdpr_pkg::*;
#(
    parameter bit SMALL_VARIANT = 1'b0  // Half depth: top address bit ignored
) (
    input  wire logic                                        clk_sys,               // System clock
    input  wire logic                                        nrst,                  // Sync reset, active low
    input  wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0]                        port_clk,              // Port clocks
    input  wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0]                        primary_select_n,      // Select, low
    input  wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0]                        secondary_select,      // Select, high
    input  wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0]                        read_write,            // High read
    input  wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0]                        output_enable_n,       // Lane enable
    input  wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0]                        upper_byte_select_n,   // Upper lane
    input  wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0]                        lower_byte_select_n,   // Lower lane
    input  wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0]                        address_load_strobe_n, // Load addr
    input  wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0]                        counter_advance_n,     // Count up
    input  wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0]                        counter_clear_n,       // Clear count
    input  wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0]                        output_latency_select, // High pipe
    input  wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0][sdpr_pkg::SDPR_ADDR_W-1:0] address,           // Address
    input  wire logic [sdpr_pkg::SDPR_NUM_PORTS-1:0][sdpr_pkg::SDPR_DATA_W-1:0] data_pins_in,      // Pin level
    output logic      [sdpr_pkg::SDPR_NUM_PORTS-1:0][sdpr_pkg::SDPR_DATA_W-1:0] data_pins_out,     // Read data
    output logic      [sdpr_pkg::SDPR_NUM_PORTS-1:0][sdpr_pkg::SDPR_DATA_W-1:0] data_pins_oe,      // Drive, high
    output logic      [sdpr_pkg::SDPR_NUM_PORTS-1:0]                        port_active           // Not standby
);
    import sdpr_pkg::*;

    localparam int DEPTH = 1 << SDPR_ADDR_W;
    localparam logic [SDPR_ADDR_W-1:0] ADDR_MASK =
        SMALL_VARIANT ? {1'b0, {(SDPR_ADDR_W-1){1'b1}}} : {SDPR_ADDR_W{1'b1}};

    // Refuse an array shape the lane split cannot serve, at elaboration
    if (SDPR_NUM_PORTS != 2 || SDPR_DATA_W != 2 * SDPR_BYTE_W) begin : g_bad_shape
        $error("sdpr_top: array shape not supported");
    end

    // ------------------------------------------------------------
    // Storage: one array per byte so lanes write independently
    // ------------------------------------------------------------
    // No reset on the array; contents stay undefined until written
    logic [SDPR_BYTE_W-1:0] mem_hi [DEPTH];
    logic [SDPR_BYTE_W-1:0] mem_lo [DEPTH];

    logic [SDPR_NUM_PORTS-1:0]                  wr_hi;
    logic [SDPR_NUM_PORTS-1:0]                  wr_lo;
    logic [SDPR_NUM_PORTS-1:0][SDPR_ADDR_W-1:0] wr_addr;
    logic [SDPR_NUM_PORTS-1:0][SDPR_DATA_W-1:0] wr_data;

    // Both ports may write in one cycle; on a same-word clash the
    // higher port lands last, which hosts must not rely on
    always_ff @(posedge clk_sys) begin
        for (int p = 0; p < SDPR_NUM_PORTS; p++) begin
            if (wr_hi[p]) begin
                mem_hi[wr_addr[p]] <= wr_data[p][SDPR_DATA_W-1:SDPR_BYTE_W];
            end
            if (wr_lo[p]) begin
                mem_lo[wr_addr[p]] <= wr_data[p][SDPR_BYTE_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Per-port logic
    // ------------------------------------------------------------
    for (genvar p = 0; p < SDPR_NUM_PORTS; p++) begin : g_port
        logic [SDPR_BUNDLE_W-1:0] pins_raw;
        logic [SDPR_BUNDLE_W-1:0] pins;
        logic                     pclk_prev_reg;
        logic                     edge_p;
        logic                     sel_now;
        logic                     oen_s;
        logic [SDPR_ADDR_W-1:0]   cnt_reg;
        logic [SDPR_ADDR_W-1:0]   cnt_next;
        logic                     sel1_reg;
        logic                     sel2_reg;
        logic                     rd1_reg;
        logic                     rd2_reg;
        logic                     ubn_reg;
        logic                     lbn_reg;
        logic [SDPR_DATA_W-1:0]   flow_reg;
        logic [SDPR_DATA_W-1:0]   pipe_reg;
        logic                     sel_eff;
        logic                     rd_eff;
        logic                     drive;

        assign pins_raw = {port_clk[p], primary_select_n[p], secondary_select[p], read_write[p],
                           output_enable_n[p], upper_byte_select_n[p], lower_byte_select_n[p],
                           address_load_strobe_n[p], counter_advance_n[p], counter_clear_n[p],
                           output_latency_select[p], address[p], data_pins_in[p]};

        // Every pin passes two flops before use; port clock is sampled too
        sdpr_sync #(
            .WIDTH (SDPR_BUNDLE_W)
        ) u_sync (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .d       (pins_raw),
            .q       (pins)
        );

        // Rising port-clock edge becomes a one-cycle enable
        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                pclk_prev_reg <= 1'b0;
            end else begin
                pclk_prev_reg <= pins[SDPR_PCLK_BIT];
            end
        end
        assign edge_p  = pins[SDPR_PCLK_BIT] & ~pclk_prev_reg;
        assign sel_now = ~pins[SDPR_CS0N_BIT] & pins[SDPR_CS1_BIT];
        assign oen_s   = pins[SDPR_OEN_BIT];

        // Address used this edge: clear, then load, then advance, then hold
        always_comb begin
            if (!pins[SDPR_CLR_BIT]) begin
                cnt_next = SDPR_ADDR_ZERO;
            end else if (!pins[SDPR_ADS_BIT]) begin
                cnt_next = pins[SDPR_ADDR_LSB +: SDPR_ADDR_W] & ADDR_MASK;
            end else if (!pins[SDPR_ADV_BIT]) begin
                cnt_next = (cnt_reg + SDPR_ADDR_ONE) & ADDR_MASK;
            end else begin
                cnt_next = cnt_reg;
            end
        end

        // Counter ignores the selects entirely
        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                cnt_reg <= SDPR_ADDR_ZERO;
            end else if (edge_p) begin
                cnt_reg <= cnt_next;
            end
        end

        // Select and byte-select staging
        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                sel1_reg <= 1'b0;
                sel2_reg <= 1'b0;
                rd1_reg  <= 1'b0;
                rd2_reg  <= 1'b0;
                ubn_reg  <= 1'b1;
                lbn_reg  <= 1'b1;
            end else if (edge_p) begin
                sel1_reg <= sel_now;
                sel2_reg <= sel1_reg;
                rd1_reg  <= sel_now & pins[SDPR_RW_BIT];
                rd2_reg  <= rd1_reg;
                ubn_reg  <= pins[SDPR_UBN_BIT];
                lbn_reg  <= pins[SDPR_LBN_BIT];
            end
        end

        // Write lands in the same system cycle as the edge
        // output enable plays no part here
        assign wr_hi[p]   = edge_p & sel_now & ~pins[SDPR_RW_BIT] & ~pins[SDPR_UBN_BIT];
        assign wr_lo[p]   = edge_p & sel_now & ~pins[SDPR_RW_BIT] & ~pins[SDPR_LBN_BIT];
        assign wr_addr[p] = cnt_next;
        assign wr_data[p] = pins[SDPR_DIN_LSB +: SDPR_DATA_W];

        // Read path; a deselected port skips the array read to idle
        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                flow_reg <= SDPR_DATA_ZERO;
                pipe_reg <= SDPR_DATA_ZERO;
            end else if (edge_p) begin
                if (sel_now & pins[SDPR_RW_BIT]) begin
                    flow_reg <= {mem_hi[cnt_next], mem_lo[cnt_next]};
                end
                pipe_reg <= flow_reg;
            end
        end

        // Latency select picks the stage for selects, read flag and data
        assign sel_eff = pins[SDPR_LAT_BIT] ? sel2_reg : sel1_reg;
        assign rd_eff  = pins[SDPR_LAT_BIT] ? rd2_reg : rd1_reg;
        assign data_pins_out[p] = pins[SDPR_LAT_BIT] ? pipe_reg : flow_reg;

        // Output enable gates lanes without waiting for a port edge;
        // it still pays the two-flop sampling delay of the system clock
        assign drive = sel_eff & rd_eff & ~oen_s;
        assign data_pins_oe[p] = {{SDPR_BYTE_W{drive & ~ubn_reg}},
                                  {SDPR_BYTE_W{drive & ~lbn_reg}}};
        assign port_active[p]  = sel_eff;
    end
endmodule
